//--- logic/upc_port_ctrl.sv
// Port control registers of the two USB serial engines and their line logic
`timescale 1ns/1ps
`include "upc_cfg.svh"

module upc_port_ctrl (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // On-chip processor access
    input wire upc_pkg::upc_req_t i_cpu_req,
    output logic [15:0] o_cpu_rdata,
    output logic o_cpu_rvalid,
    // Parallel host port access
    input wire upc_pkg::upc_req_t i_php_req,
    output logic [15:0] o_php_rdata,
    output logic o_php_rvalid,
    // Raw line levels, index is the serial engine
    input wire upc_pkg::upc_line_lvl_t [1:0] i_line_lvl,
    // Port select bit of each engine's host count register, 1 picks port B
    input wire logic [1:0] i_port_sel,
    // Per-engine role and suspend
    output logic [1:0] o_host_role,
    output logic [1:0] o_suspend,
    // Per-engine port controls
    output upc_pkg::upc_port_out_t [1:0] o_port_a,
    output upc_pkg::upc_port_out_t [1:0] o_port_b
);

    // Address of the control register of engine e
    function automatic logic [15:0] reg_addr(input logic eng);
        reg_addr = eng ? `UPC_USB2_PORT_CONTROL_ADDR
                       : `UPC_USB1_PORT_CONTROL_ADDR;
    endfunction : reg_addr

    // Line drive for a force code; J and K depend on the port speed
    function automatic logic [1:0] force_lines(
        input logic [1:0] code,
        input logic low
    );
        logic [1:0] lines;
        lines = 2'h0;
        case (code)
            `UPC_FORCE_SE0: lines = 2'h0;
            `UPC_FORCE_J: lines = low ? 2'h1 : 2'h2;
            `UPC_FORCE_K: lines = low ? 2'h2 : 2'h1;
            default: lines = 2'h0;
        endcase
        force_lines = lines;
    endfunction : force_lines

    // Port controls of a port that is switched off: nothing driven
    function automatic upc_pkg::upc_port_out_t port_idle();
        port_idle = upc_pkg::upc_port_out_t'(`UPC_PORT_OUT_RESET);
    endfunction : port_idle

    // Everything one port shows, from its own bits and the shared ones
    function automatic upc_pkg::upc_port_out_t port_out(
        input logic res_on,
        input logic host,
        input logic low,
        input logic [1:0] code,
        input logic marker_on,
        input logic active,
        input logic susp
    );
        upc_pkg::upc_port_out_t p;
        logic [1:0] lines;
        p = port_idle();
        lines = force_lines(code, low);
        // Resistors follow role and speed only while enabled
        p.pd_dp = res_on & host;
        p.pd_dm = res_on & host;
        p.pu_dp = res_on & ~host & ~low;
        p.pu_dm = res_on & ~host & low;
        // Forcing ignores the port select; suspend keeps the driver off
        p.drv_oe_n = (code == `UPC_FORCE_NORMAL) | susp;
        p.drv_dp = lines[1];
        p.drv_dm = lines[0];
        // Full speed sends SOF, low speed sends keep-alive EOP
        p.sof_on = marker_on & host & active & ~low & ~susp;
        p.eop_on = marker_on & host & active & low & ~susp;
        p.active = active;
        p.low_speed = low;
        // Powered-down transceiver neither sends nor receives
        p.xcvr_on = active & ~susp;
        port_out = p;
    endfunction : port_out

    // Host role serves both ports, device role only the selected one
    function automatic logic port_active(
        input logic host,
        input logic sel_b,
        input logic is_b
    );
        port_active = host | (sel_b == is_b);
    endfunction : port_active

    // A write by one master that lands on the register of engine eng
    function automatic logic wr_hit(
        input upc_pkg::upc_req_t req,
        input logic eng
    );
        wr_hit = req.wr & (req.addr == reg_addr(eng));
    endfunction : wr_hit

    // Next control word; the processor wins a same-cycle write
    function automatic upc_pkg::upc_ctrl_t ctrl_next(
        input logic cpu_wr,
        input logic [15:0] cpu_wdata,
        input logic php_wr,
        input logic [15:0] php_wdata,
        input upc_pkg::upc_ctrl_t cur
    );
        upc_pkg::upc_ctrl_t n;
        n = cur;
        // Status bits 15..12 are read-only, so their write bits are dropped
        if (cpu_wr)
            n = upc_pkg::upc_ctrl_t'(cpu_wdata[`UPC_CTRL_MSB:`UPC_CTRL_LSB]);
        else if (php_wr)
            n = upc_pkg::upc_ctrl_t'(php_wdata[`UPC_CTRL_MSB:`UPC_CTRL_LSB]);
        ctrl_next = n;
    endfunction : ctrl_next

    // Readback word: live line levels above the stored control bits
    function automatic logic [15:0] status_word(
        input logic [3:0] lvl,
        input upc_pkg::upc_ctrl_t ctrl
    );
        status_word = {lvl, ctrl};
    endfunction : status_word

    // Read word for one master; unmapped addresses read as zero
    function automatic logic [15:0] rd_pick(
        input logic [1:0] hit,
        input logic [15:0] word1,
        input logic [15:0] word0
    );
        logic [15:0] w;
        w = `UPC_RDATA_RESET;
        if (hit[1])
            w = word1;
        else if (hit[0])
            w = word0;
        rd_pick = w;
    endfunction : rd_pick

    // Control state
    upc_pkg::upc_ctrl_t [1:0] ctrl_q;
    upc_pkg::upc_ctrl_t [1:0] ctrl_d;

    // Synchronised line levels
    logic [7:0] line_raw;
    logic [7:0] line_sync;

    // Address decode of both masters
    logic [1:0] cpu_hit;
    logic [1:0] php_hit;
    logic [1:0] cpu_wr_hit;
    logic [1:0] php_wr_hit;

    // Readback path
    logic [15:0] rd_word [1:0];
    logic [15:0] cpu_rdata_d;
    logic [15:0] php_rdata_d;
    logic [15:0] cpu_rdata_q;
    logic [15:0] php_rdata_q;
    logic cpu_rvalid_q;
    logic php_rvalid_q;

    // Registered port controls
    upc_pkg::upc_port_out_t [1:0] port_a_d;
    upc_pkg::upc_port_out_t [1:0] port_b_d;
    upc_pkg::upc_port_out_t [1:0] port_a_q;
    upc_pkg::upc_port_out_t [1:0] port_b_q;
    logic [1:0] host_role_q;
    logic [1:0] suspend_q;

    // Line levels are asynchronous to the system clock
    assign line_raw = {i_line_lvl[1], i_line_lvl[0]};

    upc_line_sync #(
        .WIDTH(8)
    ) u_line_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(line_raw),
        .o_sync(line_sync)
    );

    // Per-engine decode, write select, readback and port logic
    for (genvar e = 0; e < 2; e++)
    begin : g_eng
        logic port_a_act;
        logic port_b_act;

        // Each engine owns its own address, so a write never spills over
        assign cpu_hit[e] = i_cpu_req.addr == reg_addr(1'(e));
        assign php_hit[e] = i_php_req.addr == reg_addr(1'(e));
        assign cpu_wr_hit[e] = wr_hit(i_cpu_req, 1'(e));
        assign php_wr_hit[e] = wr_hit(i_php_req, 1'(e));

        // Processor wins a same-cycle write to the same register
        assign ctrl_d[e] = ctrl_next(cpu_wr_hit[e], i_cpu_req.wdata,
            php_wr_hit[e], i_php_req.wdata, ctrl_q[e]);

        // Status bits on top, control bits below
        assign rd_word[e] = status_word(line_sync[e*4 +: 4],
            ctrl_q[e]);

        // Host role uses both ports, peripheral role only the selected one
        assign port_a_act = port_active(ctrl_q[e].host_role,
            i_port_sel[e], 1'b0);
        assign port_b_act = port_active(ctrl_q[e].host_role,
            i_port_sel[e], 1'b1);

        assign port_a_d[e] = port_out(
            ctrl_q[e].port_a_res_on,
            ctrl_q[e].host_role,
            ctrl_q[e].port_a_low_speed,
            ctrl_q[e].port_a_force,
            ctrl_q[e].port_a_frame_marker_on,
            port_a_act,
            ctrl_q[e].suspend);
        assign port_b_d[e] = port_out(
            ctrl_q[e].port_b_res_on,
            ctrl_q[e].host_role,
            ctrl_q[e].port_b_low_speed,
            ctrl_q[e].port_b_force,
            ctrl_q[e].port_b_frame_marker_on,
            port_b_act,
            ctrl_q[e].suspend);

        // Control bits start cleared
        always_ff @(posedge i_clk)
        begin
            if (i_rst)
                ctrl_q[e] <= upc_pkg::upc_ctrl_t'(`UPC_CTRL_RESET);
            else
                ctrl_q[e] <= ctrl_d[e];
        end
    end

    // Read mux per master; unmapped addresses read as zero
    assign cpu_rdata_d = rd_pick(cpu_hit, rd_word[1], rd_word[0]);
    assign php_rdata_d = rd_pick(php_hit, rd_word[1], rd_word[0]);

    // Read data is registered so every output leaves a flip-flop
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cpu_rdata_q <= `UPC_RDATA_RESET;
            cpu_rvalid_q <= 1'b0;
        end
        else
        begin
            cpu_rdata_q <= i_cpu_req.rd ? cpu_rdata_d : cpu_rdata_q;
            cpu_rvalid_q <= i_cpu_req.rd;
        end
    end

    // Host port read data, kept apart so each master's path stays simple
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            php_rdata_q <= `UPC_RDATA_RESET;
            php_rvalid_q <= 1'b0;
        end
        else
        begin
            php_rdata_q <= i_php_req.rd ? php_rdata_d : php_rdata_q;
            php_rvalid_q <= i_php_req.rd;
        end
    end

    // Port controls lag the register by one cycle, kept glitch-free
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            port_a_q[0] <= port_idle();
            port_a_q[1] <= port_idle();
            port_b_q[0] <= port_idle();
            port_b_q[1] <= port_idle();
        end
        else
        begin
            port_a_q <= port_a_d;
            port_b_q <= port_b_d;
        end
    end

    // Role and suspend flags, registered alongside the port controls
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            host_role_q <= 2'h0;
            suspend_q <= 2'h0;
        end
        else
        begin
            host_role_q <= {ctrl_q[1].host_role, ctrl_q[0].host_role};
            suspend_q <= {ctrl_q[1].suspend, ctrl_q[0].suspend};
        end
    end

    assign o_cpu_rdata = cpu_rdata_q;
    assign o_cpu_rvalid = cpu_rvalid_q;
    assign o_php_rdata = php_rdata_q;
    assign o_php_rvalid = php_rvalid_q;
    assign o_host_role = host_role_q;
    assign o_suspend = suspend_q;
    assign o_port_a = port_a_q;
    assign o_port_b = port_b_q;

endmodule : upc_port_ctrl

//--- logic/upc_cfg.svh
// Constants for the USB port line control block: addresses, fields, resets
`ifndef UPC_CFG_SVH
`define UPC_CFG_SVH

// Register addresses, one per serial engine
`define UPC_USB1_PORT_CONTROL_ADDR 16'hc08a
`define UPC_USB2_PORT_CONTROL_ADDR 16'hc0aa

// Field positions
`define UPC_STATUS_MSB 15
`define UPC_STATUS_LSB 12
`define UPC_CTRL_MSB 11
`define UPC_CTRL_LSB 0

// Force field encodings, most significant bit first
`define UPC_FORCE_NORMAL 2'h0
`define UPC_FORCE_J 2'h1
`define UPC_FORCE_SE0 2'h2
`define UPC_FORCE_K 2'h3

// Reset values
`define UPC_CTRL_RESET 12'h000
`define UPC_PORT_OUT_RESET 12'h020
`define UPC_RDATA_RESET 16'h0000

// Synchroniser depth
`define UPC_SYNC_STAGES 2

`endif

//--- logic/upc_pkg.sv
// Types shared by the USB port line control block
package upc_pkg;

    // Writable part of the control register, bit 11 down to bit 0
    typedef struct packed {
        logic port_b_low_speed;
        logic port_a_low_speed;
        logic host_role;
        logic port_b_res_on;
        logic port_a_res_on;
        logic [1:0] port_b_force;
        logic [1:0] port_a_force;
        logic suspend;
        logic port_b_frame_marker_on;
        logic port_a_frame_marker_on;
    } upc_ctrl_t;

    // Raw line levels of one serial engine, laid out as bits 15..12
    typedef struct packed {
        logic b_dp;
        logic b_dm;
        logic a_dp;
        logic a_dm;
    } upc_line_lvl_t;

    // Everything one port needs from the control register
    typedef struct packed {
        logic pu_dp;
        logic pu_dm;
        logic pd_dp;
        logic pd_dm;
        logic drv_dp;
        logic drv_dm;
        logic drv_oe_n;
        logic sof_on;
        logic eop_on;
        logic active;
        logic low_speed;
        logic xcvr_on;
    } upc_port_out_t;

    // One register access from either master
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } upc_req_t;

endpackage : upc_pkg

//--- logic/upc_line_sync.sv
// Two-stage synchroniser for the raw USB line levels
`timescale 1ns/1ps
`include "upc_cfg.svh"

module upc_line_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Raw and synchronised levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage, to contain metastability
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : upc_line_sync

//--- tb/upc_cable_model.sv
// Cable-side model: D+/D- levels that the far party sees on each port
`timescale 1ns/1ps

module upc_cable_model (
    // Clock
    input wire logic i_clk,
    // Port controls from the block
    input wire upc_pkg::upc_port_out_t [1:0] i_port_a,
    input wire upc_pkg::upc_port_out_t [1:0] i_port_b,
    // Levels fed back to the block
    output upc_pkg::upc_line_lvl_t [1:0] o_line_lvl
);
    logic float_q = 1'b0;

    // A floating line keeps no value, so show one that changes every cycle
    always_ff @(posedge i_clk)
        float_q <= ~float_q;

    // Forced drive wins, then a pull-up, then a pull-down
    function automatic logic lvl(input upc_pkg::upc_port_out_t p,
        input bit dp, input logic f);
        lvl = !p.drv_oe_n ? (dp ? p.drv_dp : p.drv_dm) :
            (dp ? p.pu_dp : p.pu_dm) ? 1'b1 :
            (dp ? p.pd_dp : p.pd_dm) ? 1'b0 : f;
    endfunction : lvl

    // Both serial engines, both ports
    always_comb
        for (int k = 0; k < 2; k++)
        begin
            o_line_lvl[k].b_dp = lvl(i_port_b[k], 1'b1, float_q);
            o_line_lvl[k].b_dm = lvl(i_port_b[k], 1'b0, float_q);
            o_line_lvl[k].a_dp = lvl(i_port_a[k], 1'b1, float_q);
            o_line_lvl[k].a_dm = lvl(i_port_a[k], 1'b0, float_q);
        end
endmodule : upc_cable_model

//--- tb/upc_port_ctrl_assertions.sv
// Port checks of the USB port line control block
`timescale 1ns/1ps

module upc_port_ctrl_assertions (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register access
    input wire upc_pkg::upc_req_t i_cpu_req,
    input wire upc_pkg::upc_req_t i_php_req,
    input wire logic [15:0] o_cpu_rdata,
    input wire logic o_cpu_rvalid,
    input wire logic o_php_rvalid,
    // Engine 1 controls
    input wire logic [1:0] o_host_role,
    input wire logic [1:0] o_suspend,
    input wire upc_pkg::upc_port_out_t [1:0] o_port_a
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Only the two control registers answer with data
    wire cpu_hit = i_cpu_req.addr == 16'hc08a || i_cpu_req.addr == 16'hc0aa;

    cpu_read_answer_a: assert property (i_cpu_req.rd |=> o_cpu_rvalid)
        else $error("processor read not answered");
    php_read_answer_a: assert property (i_php_req.rd |=> o_php_rvalid)
        else $error("host port read not answered");
    unmapped_zero_a: assert property (
        i_cpu_req.rd && !cpu_hit |=> o_cpu_rdata == 16'h0000)
        else $error("unmapped read returned data");
    role_follows_a: assert property (
        i_cpu_req.wr && i_cpu_req.addr == 16'hc08a
        ##1 !(i_cpu_req.wr && i_cpu_req.addr == 16'hc08a)
            && !(i_php_req.wr && i_php_req.addr == 16'hc08a)
        |-> ##1 o_host_role[0] == $past(i_cpu_req.wdata[9], 2))
        else $error("role output does not follow write");
    host_no_pullup_a: assert property (
        o_host_role[0] |-> !o_port_a[0].pu_dp && !o_port_a[0].pu_dm)
        else $error("pull-up connected in host role");
    single_pullup_a: assert property (
        !(o_port_a[0].pu_dp && o_port_a[0].pu_dm))
        else $error("two pull-ups on one port");
    pulldown_pair_a: assert property (
        o_port_a[0].pd_dp |-> o_port_a[0].pd_dm && o_host_role[0])
        else $error("pull-downs not paired with host role");
    suspend_quiet_a: assert property (
        o_suspend[0] |-> o_port_a[0].drv_oe_n && !o_port_a[0].xcvr_on)
        else $error("port active while suspended");
    marker_kind_a: assert property (
        o_port_a[0].sof_on |-> !o_port_a[0].eop_on && o_host_role[0])
        else $error("start-of-frame enabled wrongly");
endmodule : upc_port_ctrl_assertions

bind upc_port_ctrl upc_port_ctrl_assertions upc_port_ctrl_assertions_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_cpu_req(i_cpu_req),
    .i_php_req(i_php_req),
    .o_cpu_rdata(o_cpu_rdata),
    .o_cpu_rvalid(o_cpu_rvalid),
    .o_php_rvalid(o_php_rvalid),
    .o_host_role(o_host_role),
    .o_suspend(o_suspend),
    .o_port_a(o_port_a)
);

//--- tb/test_usb_port_line_control.sv
// Self-checking testbench for the USB port line control block
`timescale 1ns/1ps

module test_usb_port_line_control;
    logic i_clk;
    logic i_rst;
    upc_pkg::upc_req_t i_cpu_req;
    upc_pkg::upc_req_t i_php_req;
    logic [15:0] o_cpu_rdata;
    logic [15:0] o_php_rdata;
    logic o_cpu_rvalid;
    logic o_php_rvalid;
    upc_pkg::upc_line_lvl_t [1:0] i_line_lvl;
    logic [1:0] i_port_sel;
    logic [1:0] o_host_role;
    logic [1:0] o_suspend;
    upc_pkg::upc_port_out_t [1:0] o_port_a;
    upc_pkg::upc_port_out_t [1:0] o_port_b;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] rv;
    logic [15:0] e;
    logic [1:0] c;
    logic dp;

    upc_port_ctrl upc_port_ctrl_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_cpu_req(i_cpu_req), .o_cpu_rdata(o_cpu_rdata),
        .o_cpu_rvalid(o_cpu_rvalid), .i_php_req(i_php_req),
        .o_php_rdata(o_php_rdata), .o_php_rvalid(o_php_rvalid),
        .i_line_lvl(i_line_lvl), .i_port_sel(i_port_sel),
        .o_host_role(o_host_role), .o_suspend(o_suspend),
        .o_port_a(o_port_a), .o_port_b(o_port_b));

    upc_cable_model upc_cable_model_inst (.i_clk(i_clk),
        .i_port_a(o_port_a), .i_port_b(o_port_b), .o_line_lvl(i_line_lvl));

    // 50 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // Cut a hang short
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [15:0] s,
        input logic [15:0] x);
        checks_done++;
        if (s !== x)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    // One access, then an idle edge so no strobe is raised twice at once
    task automatic acc(input bit h, input bit we, input logic [15:0] a,
        input logic [15:0] d);
        upc_pkg::upc_req_t r;
        r = '{a, we, ~we, d};
        if (h)
            i_php_req = r;
        else
            i_cpu_req = r;
        step(1);
        rv = h ? o_php_rdata : o_cpu_rdata;
        if (!we)
            chk("rvalid", {15'h0, h ? o_php_rvalid : o_cpu_rvalid},
                16'h1);
        i_cpu_req = '0;
        i_php_req = '0;
        step(1);
    endtask : acc

    task automatic rd(input bit h, input logic [15:0] a,
        input logic [15:0] x, input logic [15:0] m);
        acc(h, 1'b0, a, 16'h0000);
        chk("rdata", rv & m, x);
    endtask : rd

    initial
    begin
        i_rst = 1'b1;
        i_cpu_req = '0;
        i_php_req = '0;
        i_port_sel = 2'h0;
        step(4);
        i_rst = 1'b0;
        rd(1'b0, 16'hc08a, 16'h0000, 16'h0fff);
        rd(1'b1, 16'hc0aa, 16'h0000, 16'h0fff);
        // Every speed, role and enable combination on both ports
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b0, 1'b1, 16'hc08a, {4'h0, i[2], i[2], i[1], i[0], i[0],
                7'h00});
            e = {12'h0, i[0] & !i[1] & !i[2], i[0] & !i[1] & i[2],
                i[0] & i[1], i[0] & i[1]};
            chk("res_a", {12'h0, o_port_a[0][11:8]}, e);
            chk("res_b", {12'h0, o_port_b[0][11:8]}, e);
            chk("role", {15'h0, o_host_role[0]}, {15'h0, i[1]});
            chk("speed", {14'h0, o_port_b[0][1], o_port_a[0][1]},
                {14'h0, i[2], i[2]});
        end
        // Every force code at both speeds, read back through the lines
        for (int i = 0; i < 8; i++)
        begin
            c = i[1:0];
            dp = c[0] & (c[1] ~^ i[2]);
            acc(1'b0, 1'b1, 16'hc08a, {4'h0, i[2], i[2], 3'h0, c, c, 3'h0});
            e = {13'h0, c == 2'h0, dp, c[0] & !dp};
            chk("frc_a", {13'h0, o_port_a[0][5],
                o_port_a[0][7:6] & {2{c != 2'h0}}}, e);
            chk("frc_b", {13'h0, o_port_b[0][5],
                o_port_b[0][7:6] & {2{c != 2'h0}}}, e);
            step(3);
            rd(1'b0, 16'hc08a, {e[1:0], e[1:0], 12'h0},
                c != 2'h0 ? 16'hf000 : 16'h0000);
        end
        // Suspend overrides forcing on both ports and powers the port A transceiver down
        acc(1'b0, 1'b1, 16'hc08a, 16'h003c);
        chk("susp", {12'h0, o_suspend[0], o_port_a[0][5], o_port_a[0][0],
            o_port_b[0][5]}, 16'hd);
        // Host role frame markers: start-of-frame at full, end at low speed
        for (int i = 0; i < 2; i++)
        begin
            acc(1'b0, 1'b1, 16'hc08a, {4'h0, i[0], i[0], 1'b1, 7'h0, 2'h3});
            chk("mark", {14'h0, o_port_a[0][4:3]},
                {14'h0, !i[0], i[0]});
        end
        // Device role serves only the selected port
        acc(1'b0, 1'b1, 16'hc08a, 16'h0000);
        chk("act", {14'h0, o_port_b[0][2], o_port_a[0][2]}, 16'h1);
        i_port_sel = 2'h1;
        step(2);
        chk("act", {14'h0, o_port_b[0][2], o_port_a[0][2]}, 16'h2);
        // Engine 2 through the host port, read by the processor
        acc(1'b1, 1'b1, 16'hc0aa, 16'hffff);
        step(3);
        rd(1'b0, 16'hc0aa, 16'h0fff, 16'hffff);
        chk("role2", {14'h0, o_host_role}, 16'h2);
        chk("port2a", {4'h0, o_port_a[1]} & 16'h0f3f, 16'h0326);
        chk("port2b", {4'h0, o_port_b[1]} & 16'h0f3f, 16'h0326);
        chk("susp2", {14'h0, o_suspend}, 16'h2);
        // Unmapped place: write dropped, read empty
        acc(1'b0, 1'b1, 16'hc08c, 16'h0fff);
        rd(1'b0, 16'hc08c, 16'h0000, 16'hffff);
        rd(1'b1, 16'hc08a, 16'h0000, 16'h0fff);
        conclude();
    end
endmodule : test_usb_port_line_control
